// ### core/dgo_top.sv
/*
 dgo_top: 40-channel calibration datapath with wishbone register access,
 busy flag, output-load strobe handling and post-reset sequence.
 assumes a classic wishbone master on clk_sys and an async strobe pin.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - code is (gain+1)*input/2^14 plus offset minus 2^13
// - converter code is 14 bits, midscale after reset
// - 14-bit input code register, midscale default
// - 13-bit gain register, all ones default
// - 14-bit offset register, 0x2000 default
// - out of range result clamps, never wraps
// - 40 channels in four groups of ten
// - converter code is straight binary tap select
// - writes to input, gain or offset trigger recompute, busy low meanwhile
// - strobe during recompute busy remembered, loads after busy; strobe during reset sequence not remembered
// - reset runs 100 us sequence restoring defaults
module dgo_top #(
  parameter int RESET_SEQ_CYC = dgo_pkg::RESET_SEQ_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dgo_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // device pins
  input wire logic output_load_strobe_b,
  output logic busy_b,
  output logic output_ground_reference_hold,
  output logic [dgo_pkg::CH_NUM*dgo_pkg::CODE_W-1:0] dac_tap_code
);
  import dgo_pkg::*;
  localparam int PTR_W = CH_FIELD_W;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // one register set per channel
  logic [CODE_W-1:0] in_reg [CH_NUM];
  logic [GAIN_W-1:0] gain_reg [CH_NUM];
  logic [CODE_W-1:0] off_reg [CH_NUM];
  logic [CODE_W-1:0] conv_reg [CH_NUM];
  logic [CH_NUM-1:0] dirty_reg;
  logic [CH_NUM-1:0] dirty_next;
  logic [PTR_W-1:0] ptr_reg;
  dgo_state_t state_reg;
  logic [SEQ_CNT_W-1:0] seq_cnt_reg;
  logic busy_b_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] rdata;
  logic ld_meta_reg;
  logic ld_s2_reg;
  logic ld_s3_reg;
  logic ld_low_reg;
  logic pend_reg;
  logic hold_reg;
  logic [CH_NUM*CODE_W-1:0] dac_tap_reg;
  logic run;
  logic req;
  logic wr_fire;
  logic ch_hit;
  logic st_hit;
  logic load_fire;
  logic [PTR_W-1:0] ch_idx;
  logic [1:0] fsel;
  logic [CODE_W-1:0] cc_code;
  logic cc_over;
  logic cc_under;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign run = (state_reg == DGO_RUN);
  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign ch_idx = wb_adr_i[CH_LSB +: PTR_W];
  assign fsel = wb_adr_i[FIELD_LSB +: 2];
  assign ch_hit = (wb_adr_i[ADDR_W-1:CH_LSB+PTR_W] == '0) && (ch_idx < PTR_W'(CH_NUM));
  assign st_hit = (wb_adr_i == STATUS_ADDR);
  // writes during the reset sequence are acknowledged but dropped
  assign wr_fire = req && wb_we_i && run && ch_hit;

  function automatic logic [CODE_W-1:0] merge_code(input logic [CODE_W-1:0] old,
                                                   input logic [31:0] d,
                                                   input logic [3:0] s);
    logic [CODE_W-1:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[CODE_W-1:8] = d[CODE_W-1:8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // channel registers
  // ----------------------------------------------------------------
  // only the addressed channel changes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < CH_NUM; i++) begin
        in_reg[i] <= INPUT_RST;
        gain_reg[i] <= GAIN_RST;
        off_reg[i] <= OFFSET_RST;
      end
    end else if (wr_fire) begin
      unique case (fsel)
        FIELD_INPUT: in_reg[ch_idx] <= merge_code(in_reg[ch_idx], wb_dat_i, wb_sel_i);
        FIELD_GAIN: gain_reg[ch_idx] <=
          GAIN_W'(merge_code({1'b0, gain_reg[ch_idx]}, wb_dat_i, wb_sel_i));
        FIELD_OFFSET: off_reg[ch_idx] <= merge_code(off_reg[ch_idx], wb_dat_i, wb_sel_i);
        FIELD_CONV: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // recompute sequencer
  // ----------------------------------------------------------------
  // one channel per cycle; a full sweep costs 40 cycles but needs one datapath
  dgo_calc #(.CODE_W(CODE_W), .GAIN_W(GAIN_W)) u_calc (
    .input_code(in_reg[ptr_reg]),
    .gain_coef(gain_reg[ptr_reg]),
    .offset_coef(off_reg[ptr_reg]),
    .conv_code(cc_code),
    .over_flag(cc_over),
    .under_flag(cc_under)
  );

  // input, gain or offset write marks channel dirty, set beats clear
  always_comb begin
    dirty_next = dirty_reg;
    if (run) begin
      dirty_next[ptr_reg] = 1'b0;
    end
    if (wr_fire && fsel != FIELD_CONV) begin
      dirty_next[ch_idx] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dirty_reg <= '0;
      ptr_reg <= '0;
    end else begin
      dirty_reg <= dirty_next;
      ptr_reg <= (ptr_reg == PTR_W'(CH_NUM-1)) ? '0 : ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < CH_NUM; i++) begin
        conv_reg[i] <= CONV_RST;
      end
    end else if (run && dirty_reg[ptr_reg]) begin
      conv_reg[ptr_reg] <= cc_code;
    end
  end

  // busy low while any channel pending
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_b_reg <= 1'b0;
    end else begin
      busy_b_reg <= run && !(|dirty_next);
    end
  end

  // ----------------------------------------------------------------
  // reset sequence
  // ----------------------------------------------------------------
  // sequence timer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= DGO_RESET_SEQ;
      seq_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        DGO_RESET_SEQ: begin
          if (seq_cnt_reg == SEQ_CNT_W'(RESET_SEQ_CYC-1)) begin
            state_reg <= DGO_RUN;
          end else begin
            seq_cnt_reg <= seq_cnt_reg + 1'b1;
          end
        end
        DGO_RUN: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output-load strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ld_meta_reg <= 1'b1;
      ld_s2_reg <= 1'b1;
      ld_s3_reg <= 1'b1;
      ld_low_reg <= 1'b0;
    end else begin
      ld_meta_reg <= output_load_strobe_b;
      ld_s2_reg <= ld_meta_reg;
      ld_s3_reg <= ld_s2_reg;
      if (ld_s2_reg == ld_s3_reg) begin
        ld_low_reg <= !ld_s2_reg;
      end
    end
  end

  assign load_fire = run && busy_b_reg && (ld_low_reg || pend_reg);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= 1'b0;
    end else if (run && !busy_b_reg && ld_low_reg) begin
      pend_reg <= 1'b1;
    end else if (load_fire) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < CH_NUM; i++) begin
        dac_tap_reg[i*CODE_W +: CODE_W] <= CONV_RST;
      end
      hold_reg <= 1'b1;
    end else if (load_fire) begin
      for (int i = 0; i < CH_NUM; i++) begin
        dac_tap_reg[i*CODE_W +: CODE_W] <= conv_reg[i];
      end
      hold_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read path and acknowledge
  // ----------------------------------------------------------------
  always_comb begin
    rdata = '0;
    if (st_hit) begin
      rdata[ST_BUSY_B_BIT] = busy_b_reg;
      rdata[ST_PEND_BIT] = pend_reg;
      rdata[ST_SEQ_BIT] = !run;
      rdata[ST_HOLD_BIT] = hold_reg;
    end else if (ch_hit) begin
      unique case (fsel)
        FIELD_INPUT: rdata = 32'(in_reg[ch_idx]);
        FIELD_GAIN: rdata = 32'(gain_reg[ch_idx]);
        FIELD_OFFSET: rdata = 32'(off_reg[ch_idx]);
        FIELD_CONV: rdata = 32'(conv_reg[ch_idx]);
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      ack_reg <= req;
      if (req) begin
        dat_reg <= wb_we_i ? 32'h0000_0000 : rdata;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign busy_b = busy_b_reg;
  assign output_ground_reference_hold = hold_reg;
  assign dac_tap_code = dac_tap_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  property p_ack_single;
    req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack not single cycle");

  // full gain coefficient over the 2^14 divisor halves the input
  property p_unity;
    (gain_reg[ptr_reg] == GAIN_RST && off_reg[ptr_reg] == OFFSET_BIAS)
      |-> cc_code == {1'b0, in_reg[ptr_reg][CODE_W-1:1]};
  endproperty
  a_unity: assert property (p_unity) else $error("default coefficients gave wrong code");

  property p_seq_midscale;
    $rose(run) |-> (conv_reg[0] == CONV_RST && dac_tap_reg[CODE_W-1:0] == CONV_RST);
  endproperty
  a_seq_midscale: assert property (p_seq_midscale) else $error("no midscale");

  property p_input_wr;
    (wr_fire && fsel == FIELD_INPUT && wb_sel_i == 4'hf)
      |=> in_reg[$past(ch_idx)] == $past(wb_dat_i[CODE_W-1:0]);
  endproperty
  a_input_wr: assert property (p_input_wr) else $error("input write lost");

  property p_clamp_hi;
    cc_over |-> cc_code == CODE_MAX;
  endproperty
  a_clamp_hi: assert property (p_clamp_hi) else $error("overflow not clamped");

  property p_clamp_lo;
    cc_under |-> cc_code == CODE_MIN;
  endproperty
  a_clamp_lo: assert property (p_clamp_lo) else $error("underflow not clamped");

  property p_wide_ovf;
    (in_reg[ptr_reg] == CODE_MAX && gain_reg[ptr_reg] == GAIN_RST && off_reg[ptr_reg] == CODE_MAX)
      |-> cc_code == CODE_MAX - 14'h0001 && !cc_over && !cc_under;
  endproperty
  // largest operands stop one short of full scale; a narrow sum would wrap here
  a_wide_ovf: assert property (p_wide_ovf) else $error("wide sum wrapped");

  property p_busy_on_write;
    (wr_fire && fsel != FIELD_CONV) |=> !busy_b ##1 (!busy_b || dirty_reg == '0);
  endproperty
  a_busy_on_write: assert property (p_busy_on_write) else $error("busy not low");

  property p_pend_load;
    (pend_reg && busy_b_reg && run)
      |=> (dac_tap_reg[CODE_W-1:0] == $past(conv_reg[0])) && !pend_reg && !hold_reg;
  endproperty
  a_pend_load: assert property (p_pend_load) else $error("stored load lost");

  property p_seq_len;
    $rose(run) |-> $past(seq_cnt_reg) == SEQ_CNT_W'(RESET_SEQ_CYC-1) && !busy_b;
  endproperty
  a_seq_len: assert property (p_seq_len) else $error("reset sequence length");

  property p_seq_busy;
    !run |-> !busy_b && !pend_reg;
  endproperty
  a_seq_busy: assert property (p_seq_busy) else $error("busy high in sequence");

  // a 13-bit gain cannot overflow, so underflow is the reachable clamp
  c_clamp: cover property (run && dirty_reg[ptr_reg] && cc_under);
  c_pend: cover property (pend_reg ##[1:80] load_fire);
  c_write: cover property (wr_fire && fsel == FIELD_GAIN);
endmodule // dgo_top

// ### core/dgo_pkg.sv
/*
 dgo_pkg: constants for the per-channel gain/offset calibration block:
 register map, field layout, reset values, timing and state types.
 assumes a 50 MHz system clock and a 32-bit classic wishbone slave port.
*/
package dgo_pkg;
  // ----------------------------------------------------------------
  // datapath shape
  // ----------------------------------------------------------------
  localparam int CH_NUM = 40;
  localparam int GROUP_NUM = 4;
  localparam int GROUP_SIZE = 10;
  localparam int CODE_W = 14;
  localparam int GAIN_W = 13;
  localparam logic [CODE_W-1:0] INPUT_RST = 14'h2000;
  localparam logic [GAIN_W-1:0] GAIN_RST = 13'h1fff;
  localparam logic [CODE_W-1:0] OFFSET_RST = 14'h2000;
  localparam logic [CODE_W-1:0] CONV_RST = 14'h2000;
  localparam logic [CODE_W-1:0] OFFSET_BIAS = 14'h2000;
  localparam logic [CODE_W-1:0] CODE_MAX = 14'h3fff;
  localparam logic [CODE_W-1:0] CODE_MIN = 14'h0000;
  // ----------------------------------------------------------------
  // register map: byte address = ch * 16 + field * 4
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int CH_LSB = 4;
  localparam int CH_FIELD_W = 6;
  localparam int FIELD_LSB = 2;
  localparam logic [1:0] FIELD_INPUT = 2'h0;
  localparam logic [1:0] FIELD_GAIN = 2'h1;
  localparam logic [1:0] FIELD_OFFSET = 2'h2;
  localparam logic [1:0] FIELD_CONV = 2'h3;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h400;
  localparam int ST_BUSY_B_BIT = 0;
  localparam int ST_PEND_BIT = 1;
  localparam int ST_SEQ_BIT = 2;
  localparam int ST_HOLD_BIT = 3;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_SEQ_NS = 100000;
  localparam int RESET_SEQ_CYC = RESET_SEQ_NS / CLK_PERIOD_NS;
  localparam int SEQ_CNT_W = 16;
  typedef enum logic [0:0] {DGO_RESET_SEQ, DGO_RUN} dgo_state_t;
endpackage

// ### core/dgo_calc.sv
/*
 dgo_calc: combinational transfer function of one channel,
 scaled input plus offset, clamped to the code range.
 assumes unsigned coefficients as stored in the channel registers.
*/
`timescale 1ns/1ps
module dgo_calc #(
  parameter int CODE_W = dgo_pkg::CODE_W,
  parameter int GAIN_W = dgo_pkg::GAIN_W
) (
  // operands
  input wire logic [CODE_W-1:0] input_code,
  input wire logic [GAIN_W-1:0] gain_coef,
  input wire logic [CODE_W-1:0] offset_coef,
  // result
  output logic [CODE_W-1:0] conv_code,
  output logic over_flag,
  output logic under_flag
);
  import dgo_pkg::*;
  logic [CODE_W-1:0] gain_p1;
  logic [2*CODE_W-1:0] prod;
  logic [CODE_W-1:0] scaled;
  logic signed [CODE_W+1:0] sum;
  assign gain_p1 = {1'b0, gain_coef} + CODE_W'(1);
  assign prod = (2*CODE_W)'(input_code) * (2*CODE_W)'(gain_p1);
  // non-negative product, so the shift truncates toward zero
  assign scaled = prod[2*CODE_W-1:CODE_W];
  assign sum = $signed({2'b00, scaled}) + $signed({2'b00, offset_coef})
    - $signed({2'b00, OFFSET_BIAS});
  assign under_flag = sum[CODE_W+1];
  assign over_flag = !sum[CODE_W+1] && sum[CODE_W];
  assign conv_code = under_flag ? CODE_MIN : (over_flag ? CODE_MAX : sum[CODE_W-1:0]);
endmodule // dgo_calc

// ### verif/dgo_host_model.sv
/*
 dgo_host_model: host stand-in, a classic wishbone master that writes
 and reads channel registers one request at a time.
 assumes the slave acks on clk_sys and drops ack the cycle after.
*/
`timescale 1ns/1ps
module dgo_host_model (
  // clock
  input wire logic clk_sys,
  // wishbone master side
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [dgo_pkg::ADDR_W-1:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat_w,
  input wire logic [31:0] dat_r,
  input wire logic ack
);
  import dgo_pkg::*;

  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h000;
    sel = 4'h0;
    dat_w = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // single transfer
  // ----------------------------------------------------------------
  // one register per access
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat_w <= d;
    @(posedge clk_sys);
    while (ack !== 1'b1) @(posedge clk_sys);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // released lines carry junk so stale values are never trusted
    adr <= ~a;
    dat_w <= ~d;
  endtask
endmodule // dgo_host_model

// ### verif/test_dgo_top.sv
/*
 test_dgo_top: self-checking bench for the calibration datapath.
 assumes the host model drives the bus and a short reset sequence.
*/
`timescale 1ns/1ps
module test_dgo_top;
  import dgo_pkg::*;
  localparam int SEQ = 20;
  logic clk_sys, rst_b, cyc, stb, we, ack, strobe_b, busy_b, hold;
  logic [ADDR_W-1:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, q;
  logic [CH_NUM*CODE_W-1:0] taps;
  int num_errors, cmp_count;
  logic [13:0] cx [3] = '{14'h1234, 14'h3fff, 14'h0100};
  logic [12:0] cm [3] = '{13'h0fff, 13'h1fff, 13'h0000};
  logic [13:0] cc [3] = '{14'h2100, 14'h3fff, 14'h0000};

  dgo_top #(.RESET_SEQ_CYC(SEQ)) dgo_top_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .output_load_strobe_b(strobe_b), .busy_b(busy_b),
    .output_ground_reference_hold(hold), .dac_tap_code(taps));
  dgo_host_model dgo_host_model_inst (
    .clk_sys(clk_sys), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat_w(dat_w), .dat_r(dat_r), .ack(ack));

  // ----------------------------------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    rst_b = 1'b0;
    strobe_b = 1'b1;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    $display("watchdog expired");
    close_out();
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pin(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  function automatic logic [ADDR_W-1:0] adr_of(input int ch, input logic [1:0] f);
    return ADDR_W'(ch * 16 + int'(f) * 4);
  endfunction
  task automatic wr(input int ch, input logic [1:0] f, input logic [31:0] d);
    logic [31:0] dummy;
    dgo_host_model_inst.xfer(1'b1, adr_of(ch, f), d, dummy);
  endtask
  task automatic rd(input int ch, input logic [1:0] f, output logic [31:0] d);
    dgo_host_model_inst.xfer(1'b0, adr_of(ch, f), 32'h0000_0000, d);
  endtask
  // expected code: scaled input plus offset, clamped, never wrapped
  function automatic logic [13:0] model(input logic [13:0] x, input logic [12:0] g,
                                        input logic [13:0] o);
    int s;
    s = ((int'(g) + 1) * int'(x)) / 16384 + int'(o) - 8192;
    if (s < 0) return CODE_MIN;
    if (s > 16383) return CODE_MAX;
    return s[13:0];
  endfunction
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge clk_sys);
    while (busy_b !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    chk_pin("busy_b idle", 1'b1, busy_b);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    @(posedge rst_b);
    @(posedge clk_sys);
    chk_pin("busy_b in sequence", 1'b0, busy_b);
    chk_pin("hold after reset", 1'b1, hold);
    chk("tap default", 32'(CONV_RST), 32'(taps[0 +: 14]));
    dgo_host_model_inst.xfer(1'b0, STATUS_ADDR, 32'h0, q);
    chk("status in sequence", 32'h0000_000c, q);
    wr(3, FIELD_INPUT, 32'h0000_0100);
    wait_idle();
    dgo_host_model_inst.xfer(1'b0, STATUS_ADDR, 32'h0, q);
    chk("status after sequence", 32'h0000_0009, q);
    foreach (cx[i]) begin
      rd(i == 0 ? 0 : (i == 1 ? 39 : 3), FIELD_INPUT, q);
      chk("input default", 32'(INPUT_RST), q);
      rd(i == 0 ? 0 : (i == 1 ? 39 : 3), FIELD_GAIN, q);
      chk("gain default", 32'(GAIN_RST), q);
      rd(i == 0 ? 0 : (i == 1 ? 39 : 3), FIELD_OFFSET, q);
      chk("offset default", 32'(OFFSET_RST), q);
      rd(i == 0 ? 0 : (i == 1 ? 39 : 3), FIELD_CONV, q);
      chk("conv default", 32'(CONV_RST), q);
    end
    $display("test reset defaults done");
    foreach (cx[i]) begin
      wr(5, FIELD_INPUT, 32'(cx[i]));
      wr(5, FIELD_GAIN, 32'(cm[i]));
      wr(5, FIELD_OFFSET, 32'(cc[i]));
      wait_idle();
      rd(5, FIELD_CONV, q);
      chk("conv code", 32'(model(cx[i], cm[i], cc[i])), q);
      rd(5, FIELD_GAIN, q);
      chk("gain readback", 32'(cm[i]), q);
      rd(6, FIELD_CONV, q);
      chk("neighbour conv", 32'(CONV_RST), q);
    end
    chk("tap before load", 32'(CONV_RST), 32'(taps[5*14 +: 14]));
    $display("test transfer function done");
    wr(5, FIELD_CONV, 32'h0000_1555);
    rd(5, FIELD_CONV, q);
    chk("conv read only", 32'(model(cx[2], cm[2], cc[2])), q);
    dgo_host_model_inst.xfer(1'b1, 12'h3fc, 32'h0000_1234, q);
    dgo_host_model_inst.xfer(1'b0, 12'h3fc, 32'h0, q);
    chk("unmapped read", 32'h0000_0000, q);
    $display("test access kinds done");
    wr(39, FIELD_INPUT, 32'h0000_3fff);
    strobe_b <= 1'b0;
    repeat (6) @(posedge clk_sys);
    strobe_b <= 1'b1;
    wait_idle();
    repeat (3) @(posedge clk_sys);
    chk("tap 39", 32'(model(14'h3fff, GAIN_RST, OFFSET_RST)), 32'(taps[39*14 +: 14]));
    chk("tap 5", 32'(model(cx[2], cm[2], cc[2])), 32'(taps[5*14 +: 14]));
    chk("tap 6", 32'(CONV_RST), 32'(taps[6*14 +: 14]));
    chk_pin("hold after load", 1'b0, hold);
    $display("test output load done");
    close_out();
  end
endmodule // test_dgo_top
